// ### dpr_pkg.sv
package dpr_pkg;

    // Register map of the control pair reached through the frame decoder
    localparam logic [4:0] ADDR_CTRL2 = 5'h02;
    localparam logic [4:0] ADDR_CTRL3 = 5'h03;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Halfbridge, PWM and DAC control fields
    localparam int C2_REC1 = 15;
    localparam int C2_REC2 = 14;
    localparam int C2_REC3 = 13;
    localparam int C2_REC_PD = 9;
    localparam int C2_INT_PWM = 8;
    localparam int C2_OUT1_SEL = 7;
    localparam int C2_OUT2_SEL = 6;
    localparam int C2_OUT3_SEL = 5;
    localparam int C2_PD_SEL = 1;
    localparam int C2_FS = 0;
    localparam logic [15:0] CTRL2_MASK = 16'hE3E3;

    // Recovery, PWM and sense control fields
    localparam int C3_REC4 = 14;
    localparam int C3_REC5 = 13;
    localparam int C3_REC6 = 12;
    localparam int C3_REC7 = 11;
    localparam int C3_OUT4_SEL = 9;
    localparam int C3_OUT5_SEL = 8;
    localparam int C3_OUT6_SEL = 7;
    localparam int C3_OUT7_SEL = 6;
    localparam int C3_REC_FAST = 5;
    localparam int C3_VREC_OFF = 4;
    localparam int C3_IS_LSB = 0;
    localparam logic [15:0] CTRL3_MASK = 16'h7BFF;

    // Sense select codes
    localparam logic [3:0] IS_OUT4 = 4'h7;
    localparam logic [3:0] IS_OUT5 = 4'h8;
    localparam logic [3:0] IS_OUT6 = 4'h9;
    localparam logic [3:0] IS_OUT7 = 4'hA;

    // Highest DAC code whose level stays under the 1.2 V clamp
    localparam logic [5:0] DAC_CLAMP_CODE = 6'h33;

    // Recovery delays, in microseconds, and their cycle counts
    localparam int CLK_MHZ = 25;
    localparam int OCR_SLOW_TIME_US = 1000;
    localparam int OCR_FAST_TIME_US = 100;
    localparam int OCR_SLOW_CYC = OCR_SLOW_TIME_US * CLK_MHZ;
    localparam int OCR_FAST_CYC = OCR_FAST_TIME_US * CLK_MHZ;

    // Channel numbering: 0..6 are outputs 1..7, 7 is the EC pull-down
    localparam int NCH = 8;

    typedef enum logic [2:0] {
        SENSE_OFF  = 3'b000,
        SENSE_OUT4 = 3'b001,
        SENSE_OUT5 = 3'b010,
        SENSE_OUT6 = 3'b011,
        SENSE_OUT7 = 3'b100
    } dpr_sense_t;

endpackage

// ### dpr_ocr_if.sv
`timescale 1ns/100ps
interface dpr_ocr_if #(
    parameter int N = 8
);
    logic clr;
    logic [N-1:0] evt;
    logic [N-1:0] rec_en;
    logic [N-1:0] fast;
    logic [N-1:0] drv_en;
    logic [N-1:0] flag_clr;
    logic [N-1:0] off;
    logic [N-1:0] flag;

    modport ctrl (output clr, evt, rec_en, fast, drv_en, flag_clr,
                  input off, flag);
    modport engine (input clr, evt, rec_en, fast, drv_en, flag_clr,
                    output off, flag);
endinterface

// ### dpr_ocr_engine.sv
`timescale 1ns/100ps
module dpr_ocr_engine
    import dpr_pkg::*;
#(
    parameter int N = 8,
    parameter int CW = 16,
    parameter int SLOW_CYC = OCR_SLOW_CYC,
    parameter int FAST_CYC = OCR_FAST_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    dpr_ocr_if.engine oc
);

    // Refuse delays that the down-counter cannot hold
    if (SLOW_CYC < 1 || FAST_CYC < 1 || SLOW_CYC > 2**CW ||
        FAST_CYC > 2**CW) begin : g_bad_delay
        $error("Recovery delays do not fit the counter");
    end

    logic [N-1:0][CW-1:0] cnt_r;

    // One shutdown latch, delay counter and sticky flag per channel
    for (genvar i = 0; i < N; i++) begin : g_ch
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                oc.off[i] <= 1'b0;
                cnt_r[i] <= '0;
            end else if (oc.clr) begin
                oc.off[i] <= 1'b0;
                cnt_r[i] <= '0;
            end else if (oc.evt[i]) begin
                oc.off[i] <= 1'b1;
                cnt_r[i] <= oc.fast[i] ? CW'(FAST_CYC - 1)
                                       : CW'(SLOW_CYC - 1);
            end else if (oc.off[i] && oc.rec_en[i]) begin
                // Automatic restart once the delay has run out
                if (cnt_r[i] == '0) begin
                    oc.off[i] <= 1'b0;
                end else begin
                    cnt_r[i] <= cnt_r[i] - CW'(1);
                end
            end else if (oc.off[i] && !oc.drv_en[i]) begin
                // Without recovery only a host switch-off rearms it
                oc.off[i] <= 1'b0;
            end
        end

        // Set wins over a host flag clear in the same cycle; the mode clear wins over set
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                oc.flag[i] <= 1'b0;
            end else if (oc.clr) begin
                oc.flag[i] <= 1'b0;
            end else if (oc.evt[i]) begin
                oc.flag[i] <= 1'b1;
            end else if (oc.flag_clr[i]) begin
                oc.flag[i] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_flag_on_event: assert property (
        (oc.evt[0] && !oc.clr) |=> (oc.flag[0] && oc.off[0]))
        else $error("Overcurrent did not set flag and shut channel");

    chk_delay_load: assert property (
        (oc.evt[4] && !oc.clr) |=>
        (cnt_r[4] == (oc.fast[4] ? CW'(FAST_CYC - 1)
                                 : CW'(SLOW_CYC - 1))))
        else $error("Recovery delay loaded with wrong length");

    chk_no_recovery: assert property (
        (oc.off[1] && !oc.rec_en[1] && oc.drv_en[1] && !oc.clr)
        |=> oc.off[1])
        else $error("Channel restarted with recovery disabled");

    chk_auto_restart: assert property (
        (oc.off[2] && oc.rec_en[2] && cnt_r[2] == '0 && !oc.evt[2] &&
         !oc.clr) |=> !oc.off[2])
        else $error("Channel not restarted after delay");

endmodule

// ### dpr_control.sv
`timescale 1ns/100ps
// Contract
// - Overcurrent flags and shuts the output; no recovery keeps it off.
// - With recovery enabled the output restarts after the programmed delay.
// - Any overcurrent also raises the global fault summary.
// - Internal PWM gates lamp outputs only while its enable bit is set.
// - Selected half-bridges conduct only while the first PWM input is high.
// - Outputs 4 and 6 follow second PWM input; 5 and 7 the first.
// - Internal PWM gates only outputs 4 to 6, never output 7.
// - DAC code passes through, clamped near 1.2 V unless full scale set.
// - Recovery frequency bit picks slow (0) or fast (1) restart delay.
// - Output 4 in bulb mode always uses the slow recovery delay.
// - Voltage flags track the supply; with recovery disabled they latch.
// - Sense codes 7, 8, 9, A pick outputs 4 to 7; others disable.
// - Shared pin drives sense only for a valid code; outputs 1-3 never.
// - EC pull-down needs DAC code zero and, if selected, first PWM high.
// - Leaving active mode clears registers and switches all stages off.
module dpr_control
    import dpr_pkg::*;
#(
    parameter int OCR_SLOW_CYCLES = OCR_SLOW_CYC,
    parameter int OCR_FAST_CYCLES = OCR_FAST_CYC,
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mode_active,
    input wire logic reg_wr_en,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    input wire logic [6:0] drv_en,
    input wire logic hs4_bulb_mode,
    input wire logic ec_pd_req,
    input wire logic [5:0] dac_code,
    input wire logic [2:0] int_pwm,
    input wire logic first_pwm_input,
    input wire logic sense_pin_in,
    output logic sense_pin_out,
    output logic sense_pin_oe_n,
    input wire logic [NCH-1:0] oc_event,
    input wire logic supply_ov_in,
    input wire logic supply_uv_in,
    input wire logic [NCH-1:0] oc_flag_clr,
    input wire logic volt_flag_clr,
    output logic [6:0] driver_output_n,
    output logic ec_pulldown_on,
    output logic [5:0] dac_level,
    output logic [3:0] sense_select_onehot,
    output logic [NCH-1:0] overcurrent_flag,
    output logic supply_overvoltage_flag,
    output logic supply_undervoltage_flag,
    output logic global_fault_summary
);

    if (CNT_W < 2 || CNT_W > 24) begin : g_bad_width
        $error("Counter width out of range");
    end

    localparam int SW = NCH + 4;

    logic [15:0] ctrl2_r;
    logic [15:0] ctrl3_r;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic pwma_s;
    logic pin_s;
    logic ov_s;
    logic uv_s;
    logic [NCH-1:0] oc_s;
    logic pwmb_s;
    logic volt_off;
    logic [NCH-1:0] rec_en;
    logic [NCH-1:0] ch_fast;
    logic [6:0] ext_sel;
    logic [6:0] ext_lvl;
    logic [6:0] gate;
    logic [6:0] on_nxt;
    logic pd_nxt;
    logic [3:0] is_code;
    dpr_sense_t sense_nxt;
    logic [3:0] onehot_nxt;

    dpr_ocr_if #(.N(NCH)) ocr ();

    // Pins pass two flops before anything looks at them
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {first_pwm_input, sense_pin_in, supply_ov_in,
                        supply_uv_in, oc_event};
            sync2_r <= sync1_r;
        end
    end

    assign {pwma_s, pin_s, ov_s, uv_s, oc_s} = sync2_r;
    // The shared pin carries the second PWM only while not sensing
    assign pwmb_s = pin_s && sense_pin_oe_n;

    // Register writes; reserved bits masked off, mode exit wipes all
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl2_r <= CTRL_RESET;
            ctrl3_r <= CTRL_RESET;
        end else if (!mode_active) begin
            ctrl2_r <= CTRL_RESET;
            ctrl3_r <= CTRL_RESET;
        end else if (reg_wr_en) begin
            if (reg_addr == ADDR_CTRL2) begin
                ctrl2_r <= reg_wr_data & CTRL2_MASK;
            end else if (reg_addr == ADDR_CTRL3) begin
                ctrl3_r <= reg_wr_data & CTRL3_MASK;
            end
        end
    end

    // Readback; unmapped offsets read zero
    always_comb begin
        if (reg_addr == ADDR_CTRL2) begin
            reg_rd_data = ctrl2_r;
        end else if (reg_addr == ADDR_CTRL3) begin
            reg_rd_data = ctrl3_r;
        end else begin
            reg_rd_data = '0;
        end
    end

    // Voltage flags: follow the supply, or latch when recovery is off
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            supply_overvoltage_flag <= 1'b0;
            supply_undervoltage_flag <= 1'b0;
        end else if (!mode_active) begin
            supply_overvoltage_flag <= 1'b0;
            supply_undervoltage_flag <= 1'b0;
        end else begin
            if (ov_s) begin
                supply_overvoltage_flag <= 1'b1;
            end else if (!ctrl3_r[C3_VREC_OFF] || volt_flag_clr) begin
                supply_overvoltage_flag <= 1'b0;
            end
            if (uv_s) begin
                supply_undervoltage_flag <= 1'b1;
            end else if (!ctrl3_r[C3_VREC_OFF] || volt_flag_clr) begin
                supply_undervoltage_flag <= 1'b0;
            end
        end
    end

    assign volt_off = supply_overvoltage_flag || supply_undervoltage_flag;

    // Recovery enables per channel and the delay choice
    assign rec_en = {ctrl2_r[C2_REC_PD], ctrl3_r[C3_REC7],
                     ctrl3_r[C3_REC6], ctrl3_r[C3_REC5], ctrl3_r[C3_REC4],
                     ctrl2_r[C2_REC3], ctrl2_r[C2_REC2], ctrl2_r[C2_REC1]};

    always_comb begin
        ch_fast = {NCH{ctrl3_r[C3_REC_FAST]}};
        // Bulb mode on output 4 keeps its own slow restart
        if (hs4_bulb_mode) begin
            ch_fast[3] = 1'b0;
        end
    end

    assign ocr.clr = !mode_active;
    assign ocr.evt = oc_s;
    assign ocr.rec_en = rec_en;
    assign ocr.fast = ch_fast;
    assign ocr.drv_en = {ec_pd_req, drv_en};
    assign ocr.flag_clr = oc_flag_clr;

    dpr_ocr_engine #(
        .N(NCH),
        .CW(CNT_W),
        .SLOW_CYC(OCR_SLOW_CYCLES),
        .FAST_CYC(OCR_FAST_CYCLES)
    ) u_ocr (
        .core_clk(core_clk),
        .reset(reset),
        .oc(ocr.engine)
    );

    assign overcurrent_flag = ocr.flag;
    // Any latched fault shows in the summary
    assign global_fault_summary = (|ocr.flag) || volt_off;

    // External PWM select and level per output
    assign ext_sel = {ctrl3_r[C3_OUT7_SEL], ctrl3_r[C3_OUT6_SEL],
                      ctrl3_r[C3_OUT5_SEL], ctrl3_r[C3_OUT4_SEL],
                      ctrl2_r[C2_OUT3_SEL], ctrl2_r[C2_OUT2_SEL],
                      ctrl2_r[C2_OUT1_SEL]};
    assign ext_lvl = {pwma_s, pwmb_s, pwma_s, pwmb_s,
                      pwma_s, pwma_s, pwma_s};

    // PWM gating; the internal unit reaches outputs 4 to 6 only
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            gate[k] = !ext_sel[k] || ext_lvl[k];
        end
        if (ctrl2_r[C2_INT_PWM]) begin
            gate[3] = gate[3] && int_pwm[0];
            gate[4] = gate[4] && int_pwm[1];
            gate[5] = gate[5] && int_pwm[2];
        end
    end

    assign on_nxt = mode_active && !volt_off ?
                    (drv_en & gate & ~ocr.off[6:0]) : 7'h00;
    assign pd_nxt = mode_active && !volt_off && ec_pd_req &&
                    (dac_code == 6'h00) && !ocr.off[7] &&
                    (!ctrl2_r[C2_PD_SEL] || pwma_s);

    // Driver stages and DAC level come from flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            driver_output_n <= 7'h00;
            ec_pulldown_on <= 1'b0;
            dac_level <= 6'h00;
        end else begin
            driver_output_n <= on_nxt;
            ec_pulldown_on <= pd_nxt;
            if (!mode_active) begin
                dac_level <= 6'h00;
            end else if (!ctrl2_r[C2_FS] && dac_code > DAC_CLAMP_CODE) begin
                dac_level <= DAC_CLAMP_CODE;
            end else begin
                dac_level <= dac_code;
            end
        end
    end

    // Sense selection decode
    assign is_code = ctrl3_r[C3_IS_LSB +: 4];
    always_comb begin
        case (is_code)
            IS_OUT4: sense_nxt = SENSE_OUT4;
            IS_OUT5: sense_nxt = SENSE_OUT5;
            IS_OUT6: sense_nxt = SENSE_OUT6;
            IS_OUT7: sense_nxt = SENSE_OUT7;
            default: sense_nxt = SENSE_OFF;
        endcase
        case (sense_nxt)
            SENSE_OUT4: onehot_nxt = 4'h1;
            SENSE_OUT5: onehot_nxt = 4'h2;
            SENSE_OUT6: onehot_nxt = 4'h4;
            SENSE_OUT7: onehot_nxt = 4'h8;
            default: onehot_nxt = 4'h0;
        endcase
    end

    // Pin drives only for a valid code; it mirrors the chosen output
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sense_select_onehot <= 4'h0;
            sense_pin_oe_n <= 1'b1;
            sense_pin_out <= 1'b0;
        end else begin
            sense_select_onehot <= onehot_nxt;
            sense_pin_oe_n <= (sense_nxt == SENSE_OFF);
            sense_pin_out <= |(onehot_nxt & on_nxt[6:3]);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_oc_output_off: assert property (
        (oc_s[0] && mode_active) |-> ##2 !driver_output_n[0])
        else $error("Output stayed on after overcurrent");

    chk_summary_raised: assert property (
        (oc_s[5] && mode_active) |=> global_fault_summary)
        else $error("Summary flag missed an overcurrent");

    chk_int_pwm_gate: assert property (
        (ctrl2_r[C2_INT_PWM] && !int_pwm[1]) |=> !driver_output_n[4])
        else $error("Internal PWM low did not gate output 5");

    chk_halfbridge_pwm: assert property (
        (ctrl2_r[C2_OUT2_SEL] && !pwma_s) |=> !driver_output_n[1])
        else $error("Half-bridge on while first PWM low");

    chk_hs_second_pwm: assert property (
        (ctrl3_r[C3_OUT6_SEL] && !pwmb_s) |=> !driver_output_n[5])
        else $error("Output 6 on while second PWM low");

    chk_out7_no_int: assert property (
        (mode_active && !volt_off && drv_en[6] && !ext_sel[6] &&
         !ocr.off[6]) |=> driver_output_n[6])
        else $error("Output 7 gated by something other than its PWM");

    chk_dac_clamp: assert property (
        (mode_active && !ctrl2_r[C2_FS] && dac_code > DAC_CLAMP_CODE)
        |=> dac_level == DAC_CLAMP_CODE)
        else $error("DAC level not clamped");

    chk_bulb_slow: assert property (
        (hs4_bulb_mode && oc_s[3] && mode_active) |=>
        (u_ocr.cnt_r[3] == CNT_W'(OCR_SLOW_CYCLES - 1)))
        else $error("Output 4 bulb mode took the fast delay");

    chk_volt_latch: assert property (
        (mode_active && ctrl3_r[C3_VREC_OFF] && supply_overvoltage_flag &&
         !volt_flag_clr) |=> supply_overvoltage_flag)
        else $error("Voltage flag dropped while latched");

    chk_sense_out4: assert property (
        (is_code == IS_OUT4) |=>
        (sense_select_onehot == 4'h1 && !sense_pin_oe_n))
        else $error("Sense code for output 4 not routed");

    chk_pulldown_dac: assert property (
        (dac_code != 6'h00) |=> !ec_pulldown_on)
        else $error("EC pull-down on with nonzero DAC code");

    chk_standby_clear: assert property (
        !mode_active |=> (ctrl2_r == 16'h0000 && ctrl3_r == 16'h0000 &&
                          driver_output_n == 7'h00))
        else $error("Standby did not clear registers and outputs");

    chk_reserved_zero: assert property (
        (reg_rd_data & ~(reg_addr == ADDR_CTRL2 ? CTRL2_MASK
                                                : CTRL3_MASK)) == 16'h0000)
        else $error("Reserved bit read as one");

endmodule

// ### dpr_host_model.sv
`timescale 1ns/100ps
// Host microcontroller on the register port: word writes, reads, flag clears
module dpr_host_model (
    input wire logic core_clk,
    input wire logic [15:0] reg_rd_data,
    output logic reg_wr_en,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wr_data,
    output logic volt_flag_clr
);
    // Idle values from time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_addr = 5'h1F;
        reg_wr_data = 16'h0000;
        volt_flag_clr = 1'b0;
    end

    // One word held for a whole edge; a gap makes the host slow
    task automatic write(input logic [4:0] a, input logic [15:0] d,
                         input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_wr_data <= ~d; // Released bus never keeps the old word
    endtask

    // Readback is combinational, so sample a cycle after the address
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        @(posedge core_clk);
        #1;
        d = reg_rd_data;
    endtask

    // Latched supply flags are cleared by the host
    task automatic clear_volt();
        @(posedge core_clk);
        volt_flag_clr <= 1'b1;
        @(posedge core_clk);
        volt_flag_clr <= 1'b0;
    endtask
endmodule

// ### driver_pwm_recovery_control_test.sv
`timescale 1ns/100ps
module driver_pwm_recovery_control_test;
    import dpr_pkg::*;
    localparam int SLOW = 20;
    localparam int FAST = 5;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic mode_active = 1'b1;
    logic [6:0] drv_en = 7'h00;
    logic bulb = 1'b0;
    logic pd_req = 1'b0;
    logic [5:0] dac_code = 6'h00;
    logic [2:0] int_pwm = 3'h0;
    logic p1 = 1'b0;
    logic p2 = 1'b0;
    logic [7:0] oc_event = 8'h00;
    logic ov_in = 1'b0;
    logic uv_in = 1'b0;
    logic [7:0] oc_clr = 8'h00;
    logic wr_en, vclr, oe_n, s_out, pd_on, ovf, uvf, gsum;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, r, c2, c3;
    logic [6:0] drv;
    logic [5:0] dac_lvl;
    logic [3:0] onehot;
    logic [7:0] ocf;
    int mismatches = 0;
    int checks_done = 0;
    int n, seed;

    always #20 core_clk = ~core_clk;

    dpr_host_model dpr_host_model_i (.core_clk(core_clk),
        .reg_rd_data(rdata), .reg_wr_en(wr_en), .reg_addr(addr),
        .reg_wr_data(wdata), .volt_flag_clr(vclr));

    dpr_control #(.OCR_SLOW_CYCLES(SLOW), .OCR_FAST_CYCLES(FAST))
    dpr_control_i (.core_clk(core_clk), .reset(reset),
        .mode_active(mode_active), .reg_wr_en(wr_en), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_rd_data(rdata), .drv_en(drv_en),
        .hs4_bulb_mode(bulb), .ec_pd_req(pd_req), .dac_code(dac_code),
        .int_pwm(int_pwm), .first_pwm_input(p1), .sense_pin_in(p2),
        .sense_pin_out(s_out), .sense_pin_oe_n(oe_n), .oc_event(oc_event),
        .supply_ov_in(ov_in), .supply_uv_in(uv_in), .oc_flag_clr(oc_clr),
        .volt_flag_clr(vclr), .driver_output_n(drv),
        .ec_pulldown_on(pd_on), .dac_level(dac_lvl),
        .sense_select_onehot(onehot), .overcurrent_flag(ocf),
        .supply_overvoltage_flag(ovf), .supply_undervoltage_flag(uvf),
        .global_fault_summary(gsum));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Gating of each output by its selected PWM source
    function automatic logic [6:0] exp_drv(logic [15:0] a, logic [15:0] b,
        logic [6:0] en, logic q1, logic q2, logic [2:0] ip);
        logic [6:0] o;
        logic g;
        for (int k = 0; k < 7; k++) begin
            if (k < 3)
                g = a[C2_OUT1_SEL - k] ? q1 : 1'b1;
            else if (k == 3 || k == 5)
                g = b[C3_OUT4_SEL + 3 - k] ? q2 : 1'b1;
            else
                g = b[C3_OUT4_SEL + 3 - k] ? q1 : 1'b1;
            if (a[C2_INT_PWM] && k <= 5 && k >= 3)
                g = g & ip[k - 3];
            o[k] = en[k] & g;
        end
        return o;
    endfunction

    function automatic logic [3:0] exp_sense(logic [3:0] is);
        case (is)
            IS_OUT4: return 4'h1;
            IS_OUT5: return 4'h2;
            IS_OUT6: return 4'h4;
            IS_OUT7: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    // Overcurrent hit: flags and shutdown, then cycles until restart
    task automatic oc_hit(input int ch, output int cnt);
        @(posedge core_clk);
        oc_event[ch] <= 1'b1;
        @(posedge core_clk);
        oc_event[ch] <= 1'b0;
        cyc(5);
        check(16'(drv[ch]), 16'h0000, "output off");
        check(16'(ocf[ch]), 16'h0001, "oc flag");
        check(16'(gsum), 16'h0001, "summary");
        cnt = 0;
        while (drv[ch] !== 1'b1 && cnt < 200) begin
            cyc(1);
            cnt++;
        end
    endtask

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        conclude();
    end

    initial begin
        seed = $urandom(39097);
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        dpr_host_model_i.read(ADDR_CTRL2, r);
        check(r, CTRL_RESET, "ctrl2 reset");
        dpr_host_model_i.read(ADDR_CTRL3, r);
        check(r, CTRL_RESET, "ctrl3 reset");
        // Random and all-ones words, reserved bits must drop
        for (int i = 0; i < 10; i++) begin
            c2 = (i < 2) ? 16'hFFFF : 16'($urandom);
            dpr_host_model_i.write(i[0] ? ADDR_CTRL3 : ADDR_CTRL2, c2,
                                   $urandom % 3);
            dpr_host_model_i.read(i[0] ? ADDR_CTRL3 : ADDR_CTRL2, r);
            check(r, c2 & (i[0] ? CTRL3_MASK : CTRL2_MASK),
                  "rw");
        end
        dpr_host_model_i.write(5'h05, 16'hFFFF, 0);
        dpr_host_model_i.read(5'h05, r);
        check(r, 16'h0000, "unmapped");
        // Every sense code
        for (int i = 0; i < 16; i++) begin
            dpr_host_model_i.write(ADDR_CTRL3, 16'(i), 0);
            cyc(4);
            check(16'(onehot), 16'(exp_sense(4'(i))), "sense");
            check(16'(oe_n), 16'(exp_sense(4'(i)) == 4'h0),
                  "oe");
        end
        // Random gating, DAC clamp and pull-down
        for (int i = 0; i < 40; i++) begin
            c2 = 16'($urandom) & 16'h03E3;
            c3 = 16'($urandom) & 16'h03C0;
            dpr_host_model_i.write(ADDR_CTRL2, c2, 0);
            dpr_host_model_i.write(ADDR_CTRL3, c3, $urandom % 2);
            @(posedge core_clk);
            drv_en <= 7'($urandom);
            p1 <= 1'($urandom);
            p2 <= 1'($urandom);
            int_pwm <= 3'($urandom);
            dac_code <= ($urandom % 3 == 0) ? 6'h00 : 6'($urandom);
            pd_req <= 1'($urandom);
            bulb <= 1'($urandom);
            cyc(6);
            check(16'(drv), 16'(exp_drv(c2, c3, drv_en, p1, p2, int_pwm)),
                  "gating");
            check(16'(dac_lvl), 16'((c2[C2_FS] || dac_code <= DAC_CLAMP_CODE)
                  ? dac_code : DAC_CLAMP_CODE), "dac");
            check(16'(pd_on), 16'(pd_req && dac_code == 6'h00 &&
                  (!c2[C2_PD_SEL] || p1)), "pulldown");
        end
        // Shared pin mirrors output 7 while that output is sensed
        dpr_host_model_i.write(ADDR_CTRL3, 16'(IS_OUT7), 0);
        @(posedge core_clk);
        drv_en <= 7'h40;
        cyc(5);
        check(16'(s_out), 16'h0001, "sense pin");
        // Overcurrent: none, fast, slow, and bulb output 4
        dpr_host_model_i.write(ADDR_CTRL2, 16'h0000, 0);
        dpr_host_model_i.write(ADDR_CTRL3, 16'h0020, 0);
        @(posedge core_clk);
        drv_en <= 7'h7F;
        bulb <= 1'b0;
        oc_hit(0, n);
        check(16'(n), 16'd200, "stays off");
        @(posedge core_clk);
        drv_en[0] <= 1'b0;
        oc_clr[0] <= 1'b1;
        @(posedge core_clk);
        oc_clr[0] <= 1'b0;
        drv_en[0] <= 1'b1;
        cyc(5);
        check(16'(ocf[0]), 16'h0000, "flag clear");
        dpr_host_model_i.write(ADDR_CTRL2, 16'h8000, 0);
        oc_hit(0, n);
        check(16'(n >= FAST - 2 && n <= FAST + 6), 16'h0001,
              "fast");
        dpr_host_model_i.write(ADDR_CTRL3, 16'h0000, 0);
        oc_hit(0, n);
        check(16'(n >= SLOW - 2 && n <= SLOW + 6), 16'h0001,
              "slow");
        dpr_host_model_i.write(ADDR_CTRL3, 16'h4020, 0);
        @(posedge core_clk);
        bulb <= 1'b1;
        oc_hit(3, n);
        check(16'(n >= SLOW - 2 && n <= SLOW + 6), 16'h0001,
              "bulb");
        @(posedge core_clk);
        oc_clr <= 8'hFF;
        @(posedge core_clk);
        oc_clr <= 8'h00;
        cyc(3);
        check(16'(gsum), 16'h0000, "summary clear");
        // Supply faults, with and without automatic recovery
        dpr_host_model_i.write(ADDR_CTRL3, 16'h0000, 0);
        @(posedge core_clk);
        ov_in <= 1'b1;
        cyc(5);
        check(16'({ovf, gsum, drv}), 16'h0180, "ov on");
        @(posedge core_clk);
        ov_in <= 1'b0;
        cyc(5);
        check(16'(ovf), 16'h0000, "ov recovers");
        dpr_host_model_i.write(ADDR_CTRL3, 16'h0010, 0);
        @(posedge core_clk);
        uv_in <= 1'b1;
        cyc(5);
        @(posedge core_clk);
        uv_in <= 1'b0;
        cyc(5);
        check(16'(uvf), 16'h0001, "uv latched");
        dpr_host_model_i.clear_volt();
        cyc(3);
        check(16'(uvf), 16'h0000, "uv cleared");
        // Standby clears registers and outputs, writes are lost
        dpr_host_model_i.write(ADDR_CTRL2, 16'hFFFF, 0);
        @(posedge core_clk);
        mode_active <= 1'b0;
        dpr_host_model_i.write(ADDR_CTRL3, 16'hFFFF, 1);
        cyc(3);
        check(16'({drv, ocf}), 16'h0000, "standby off");
        @(posedge core_clk);
        mode_active <= 1'b1;
        dpr_host_model_i.read(ADDR_CTRL2, r);
        check(r, 16'h0000, "standby ctrl2");
        dpr_host_model_i.read(ADDR_CTRL3, r);
        check(r, 16'h0000, "standby ctrl3");
        conclude();
    end
endmodule
